// *** pkg/pulse_next_data_pkg.sv ***
// constants and carrier types for the pulse next-data register bank
package pulse_next_data_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int NIB_W = 4;
   localparam int GROUPS = 4;
   localparam int SEL_W = 2;
   localparam int TIMER_CH = 4;

   // byte offsets of the registers
   localparam logic [ADDR_W-1:0] NEXT_HIGH_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] NEXT_HIGH_UPPER_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] NEXT_HIGH_LOWER_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] NEXT_LOW_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] NEXT_LOW_UPPER_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] NEXT_LOW_LOWER_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] ENABLE_HIGH_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] ENABLE_LOW_OFS = 8'h1C;
   localparam logic [ADDR_W-1:0] OUTPUT_HIGH_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] OUTPUT_LOW_OFS = 8'h24;
   localparam logic [ADDR_W-1:0] TRIG_SEL_HIGH_OFS = 8'h28;
   localparam logic [ADDR_W-1:0] TRIG_SEL_LOW_OFS = 8'h2C;

   // reset values and fixed read values
   localparam logic [REG_W-1:0] NEXT_DATA_RST = 8'h00;
   localparam logic [NIB_W-1:0] NIBBLE_RST = 4'h0;
   localparam logic [REG_W-1:0] ENABLE_RST = 8'h00;
   localparam logic [SEL_W-1:0] SEL_RST = 2'h3;
   localparam logic [NIB_W-1:0] RSVD_ONES = 4'hF;
   localparam logic [NIB_W-1:0] RSVD_ZERO = 4'h0;
   localparam logic [REG_W-1:0] READ_NONE = 8'h00;

   // group numbers: group 3 is bits 15..12, group 0 bits 3..0
   localparam int G3 = 3;
   localparam int G2 = 2;
   localparam int G1 = 1;
   localparam int G0 = 0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] data;
      logic lane0;
   } reg_wr_t;

   typedef struct packed {
      logic [REG_W-1:0] data;
      logic err;
   } reg_rd_t;
endpackage

// *** src/axil_reg_port.sv ***
// axi4-lite slave front end delivering single register accesses
`timescale 1ns/1ps
module axil_reg_port
(
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [pulse_next_data_pkg::ADDR_W-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [pulse_next_data_pkg::DATA_W-1:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [pulse_next_data_pkg::ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [pulse_next_data_pkg::DATA_W-1:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   output pulse_next_data_pkg::reg_wr_t wr_cmd_out,
   output logic wr_pulse_out,
   input wire logic wr_err_in,
   output logic [pulse_next_data_pkg::ADDR_W-1:0] rd_addr_out,
   output logic rd_pulse_out,
   input pulse_next_data_pkg::reg_rd_t rd_result_in
);
   import pulse_next_data_pkg::*;

   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [REG_W-1:0] wdata_ff;
   logic lane0_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [DATA_W-1:0] rdata_ff;

   wire aw_take = awvalid_in & awready_ff & ce_in;
   wire w_take = wvalid_in & wready_ff & ce_in;
   // both halves held and previous response gone
   wire do_write = ~awready_ff & ~wready_ff & ~bvalid_ff & ce_in;
   wire b_done = bvalid_ff & bready_in & ce_in;
   wire do_read = arvalid_in & arready_ff & ~rvalid_ff & ce_in;
   wire r_done = rvalid_ff & rready_in & ce_in;

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         lane0_ff <= 1'b0;
      end
      else
      begin
         if (aw_take)
            awaddr_ff <= awaddr_in;
         if (w_take)
         begin
            wdata_ff <= wdata_in[REG_W-1:0];
            lane0_ff <= wstrb_in[0];
         end
         awready_ff <= b_done | (awready_ff & ~aw_take);
         wready_ff <= b_done | (wready_ff & ~w_take);
         bvalid_ff <= do_write | (bvalid_ff & ~b_done);
         if (do_write)
            bresp_ff <= wr_err_in ? RESP_SLVERR : RESP_OKAY;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= '0;
      end
      else
      begin
         arready_ff <= r_done | (arready_ff & ~do_read);
         rvalid_ff <= do_read | (rvalid_ff & ~r_done);
         if (do_read)
         begin
            rdata_ff <= {{(DATA_W-REG_W){1'b0}}, rd_result_in.data};
            rresp_ff <= rd_result_in.err ? RESP_SLVERR : RESP_OKAY;
         end
      end
   end

   assign awready_out = awready_ff;
   assign wready_out = wready_ff;
   assign bvalid_out = bvalid_ff;
   assign bresp_out = bresp_ff;
   assign arready_out = arready_ff;
   assign rvalid_out = rvalid_ff;
   assign rresp_out = rresp_ff;
   assign rdata_out = rdata_ff;
   assign wr_cmd_out = {awaddr_ff, wdata_ff, lane0_ff};
   assign wr_pulse_out = do_write;
   assign rd_addr_out = araddr_in;
   assign rd_pulse_out = do_read;
endmodule

// *** src/pulse_group_slice.sv ***
// one pulse output group: next-data nibble and output-data nibble
`timescale 1ns/1ps
module pulse_group_slice
(
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [pulse_next_data_pkg::SEL_W-1:0] sel_in,
   input wire logic [pulse_next_data_pkg::TIMER_CH-1:0] compare_match_in,
   input wire logic next_wr_in,
   input wire logic out_wr_in,
   input wire logic [pulse_next_data_pkg::NIB_W-1:0] wr_data_in,
   input wire logic [pulse_next_data_pkg::NIB_W-1:0] enable_in,
   output logic trigger_out,
   output logic [pulse_next_data_pkg::NIB_W-1:0] next_data_out,
   output logic [pulse_next_data_pkg::NIB_W-1:0] output_data_out
);
   import pulse_next_data_pkg::*;

   logic [NIB_W-1:0] next_ff, out_ff;
   wire trig = compare_match_in[sel_in] & ce_in;
   wire [NIB_W-1:0] trig_bits = {NIB_W{trig}};
   // a coinciding write lands here while the old value is transferred
   wire [NIB_W-1:0] nxt_next = next_wr_in ? wr_data_in : next_ff;
   wire [NIB_W-1:0] cpu_out = out_wr_in ? wr_data_in : out_ff;
   wire [NIB_W-1:0] nxt_out = (enable_in & trig_bits & next_ff)
      | (enable_in & ~trig_bits & out_ff)
      | (~enable_in & cpu_out);

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         next_ff <= NIBBLE_RST;
         out_ff <= NIBBLE_RST;
      end
      else if (ce_in)
      begin
         next_ff <= nxt_next;
         out_ff <= nxt_out;
      end
   end

   assign trigger_out = trig;
   assign next_data_out = next_ff;
   assign output_data_out = out_ff;
endmodule

// *** src/pulse_next_data_regs.sv ***
// pulse next-data register bank with trigger transfer to output data
// Function
// - Two 8-bit next-data registers hold the next value of sixteen bits.
// - Every writable next-data bit is zero after reset.
// - Groups 2 and 3 on one trigger: eight high bits at one address.
// - Groups 2 and 3 on two triggers: bits 15..12, 11..8 at two addresses.
// - Groups 0 and 1 on one trigger: eight low bits at one address.
// - Groups 0 and 1 on two triggers: bits 7..4, 3..0 at two addresses.
// - In the split layout the unused nibble reads as ones, ignores writes.
// - A high group's selected trigger copies next data into output data.
// - A low group's selected trigger copies next data into output data.
// - Only enabled bits transfer; disabled output bits keep their value.
// - Enabled output bits ignore cpu writes; disabled ones take them.
// - A 2-bit field per group picks compare match of timer channel 0..3.
`timescale 1ns/1ps
module pulse_next_data_regs
(
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [pulse_next_data_pkg::TIMER_CH-1:0] compare_match_in,
   input wire logic [pulse_next_data_pkg::ADDR_W-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [pulse_next_data_pkg::DATA_W-1:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [pulse_next_data_pkg::ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [pulse_next_data_pkg::DATA_W-1:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [2*pulse_next_data_pkg::REG_W-1:0] pulse_out
);
   import pulse_next_data_pkg::*;

   reg_wr_t wr_cmd;
   reg_rd_t rd_result;
   logic wr_pulse, rd_pulse, wr_err;
   logic [ADDR_W-1:0] rd_addr;

   logic [REG_W-1:0] enable_high_ff, enable_low_ff;
   logic [GROUPS-1:0][SEL_W-1:0] sel_ff;
   logic [GROUPS-1:0][NIB_W-1:0] nd, od, en, wdat;
   logic [GROUPS-1:0] nw, ow, trig;

   axil_reg_port u_port
   (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .awaddr_in(awaddr_in),
      .awvalid_in(awvalid_in),
      .awready_out(awready_out),
      .wdata_in(wdata_in),
      .wstrb_in(wstrb_in),
      .wvalid_in(wvalid_in),
      .wready_out(wready_out),
      .bresp_out(bresp_out),
      .bvalid_out(bvalid_out),
      .bready_in(bready_in),
      .araddr_in(araddr_in),
      .arvalid_in(arvalid_in),
      .arready_out(arready_out),
      .rdata_out(rdata_out),
      .rresp_out(rresp_out),
      .rvalid_out(rvalid_out),
      .rready_in(rready_in),
      .wr_cmd_out(wr_cmd),
      .wr_pulse_out(wr_pulse),
      .wr_err_in(wr_err),
      .rd_addr_out(rd_addr),
      .rd_pulse_out(rd_pulse),
      .rd_result_in(rd_result)
   );

   // layout follows whether the two groups share a trigger
   wire high_shared = sel_ff[G3] == sel_ff[G2];
   wire low_shared = sel_ff[G1] == sel_ff[G0];

   // write decode, word address with the low two bits ignored
   wire [ADDR_W-1:0] wa = {wr_cmd.addr[ADDR_W-1:2], 2'b00};
   wire w_nh = (wa == NEXT_HIGH_OFS) & high_shared;
   wire w_nhu = (wa == NEXT_HIGH_UPPER_OFS) & ~high_shared;
   wire w_nhl = (wa == NEXT_HIGH_LOWER_OFS) & ~high_shared;
   wire w_nl = (wa == NEXT_LOW_OFS) & low_shared;
   wire w_nlu = (wa == NEXT_LOW_UPPER_OFS) & ~low_shared;
   wire w_nll = (wa == NEXT_LOW_LOWER_OFS) & ~low_shared;
   wire w_enh = wa == ENABLE_HIGH_OFS;
   wire w_enl = wa == ENABLE_LOW_OFS;
   wire w_odh = wa == OUTPUT_HIGH_OFS;
   wire w_odl = wa == OUTPUT_LOW_OFS;
   wire w_tsh = wa == TRIG_SEL_HIGH_OFS;
   wire w_tsl = wa == TRIG_SEL_LOW_OFS;
   wire w_hit = w_nh | w_nhu | w_nhl | w_nl | w_nlu | w_nll | w_enh
      | w_enl | w_odh | w_odl | w_tsh | w_tsl;
   wire wr_lane = wr_pulse & wr_cmd.lane0;
   assign wr_err = ~w_hit;

   // read decode
   wire [ADDR_W-1:0] ra = {rd_addr[ADDR_W-1:2], 2'b00};
   wire r_nh = (ra == NEXT_HIGH_OFS) & high_shared;
   wire r_nhu = (ra == NEXT_HIGH_UPPER_OFS) & ~high_shared;
   wire r_nhl = (ra == NEXT_HIGH_LOWER_OFS) & ~high_shared;
   wire r_nl = (ra == NEXT_LOW_OFS) & low_shared;
   wire r_nlu = (ra == NEXT_LOW_UPPER_OFS) & ~low_shared;
   wire r_nll = (ra == NEXT_LOW_LOWER_OFS) & ~low_shared;
   wire r_enh = ra == ENABLE_HIGH_OFS;
   wire r_enl = ra == ENABLE_LOW_OFS;
   wire r_odh = ra == OUTPUT_HIGH_OFS;
   wire r_odl = ra == OUTPUT_LOW_OFS;
   wire r_tsh = ra == TRIG_SEL_HIGH_OFS;
   wire r_tsl = ra == TRIG_SEL_LOW_OFS;
   wire r_hit = r_nh | r_nhu | r_nhl | r_nl | r_nlu | r_nll | r_enh
      | r_enl | r_odh | r_odl | r_tsh | r_tsl;

   wire [REG_W-1:0] rd_data =
      r_nh ? {nd[G3], nd[G2]} :
      r_nhu ? {nd[G3], RSVD_ONES} :
      r_nhl ? {RSVD_ONES, nd[G2]} :
      r_nl ? {nd[G1], nd[G0]} :
      r_nlu ? {nd[G1], RSVD_ONES} :
      r_nll ? {RSVD_ONES, nd[G0]} :
      r_enh ? enable_high_ff :
      r_enl ? enable_low_ff :
      r_odh ? {od[G3], od[G2]} :
      r_odl ? {od[G1], od[G0]} :
      r_tsh ? {sel_ff[G3], sel_ff[G2], RSVD_ONES} :
      r_tsl ? {RSVD_ZERO, sel_ff[G1], sel_ff[G0]} :
      READ_NONE;
   assign rd_result = {rd_data, ~r_hit};

   // per-group strobes; split addresses reach one nibble only
   assign nw[G3] = wr_lane & (w_nh | w_nhu);
   assign nw[G2] = wr_lane & (w_nh | w_nhl);
   assign nw[G1] = wr_lane & (w_nl | w_nlu);
   assign nw[G0] = wr_lane & (w_nl | w_nll);
   assign ow[G3] = wr_lane & w_odh;
   assign ow[G2] = wr_lane & w_odh;
   assign ow[G1] = wr_lane & w_odl;
   assign ow[G0] = wr_lane & w_odl;
   assign en[G3] = enable_high_ff[REG_W-1:NIB_W];
   assign en[G2] = enable_high_ff[NIB_W-1:0];
   assign en[G1] = enable_low_ff[REG_W-1:NIB_W];
   assign en[G0] = enable_low_ff[NIB_W-1:0];

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         enable_high_ff <= ENABLE_RST;
         enable_low_ff <= ENABLE_RST;
         sel_ff <= {GROUPS{SEL_RST}};
      end
      else if (wr_lane)
      begin
         if (w_enh)
            enable_high_ff <= wr_cmd.data;
         if (w_enl)
            enable_low_ff <= wr_cmd.data;
         if (w_tsh)
            sel_ff[G3:G2] <= wr_cmd.data[REG_W-1:NIB_W];
         if (w_tsl)
            sel_ff[G1:G0] <= wr_cmd.data[NIB_W-1:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++)
      begin : grp
         // odd groups sit in the upper nibble of each byte
         if (g % 2 == 1)
         begin : up
            assign wdat[g] = wr_cmd.data[REG_W-1:NIB_W];
         end
         else
         begin : lo
            assign wdat[g] = wr_cmd.data[NIB_W-1:0];
         end
         // transfer, enable gating and cpu write blocking per nibble
         pulse_group_slice u_slice
         (
            .ref_clk_in(ref_clk_in),
            .resetn_in(resetn_in),
            .ce_in(ce_in),
            .sel_in(sel_ff[g]),
            .compare_match_in(compare_match_in),
            .next_wr_in(nw[g]),
            .out_wr_in(ow[g]),
            .wr_data_in(wdat[g]),
            .enable_in(en[g]),
            .trigger_out(trig[g]),
            .next_data_out(nd[g]),
            .output_data_out(od[g])
         );
      end
   endgenerate

   assign pulse_out = {od[G3], od[G2], od[G1], od[G0]};

   // checks
   wire [REG_W-1:0] nd_high = {nd[G3], nd[G2]};
   wire [REG_W-1:0] nd_low = {nd[G1], nd[G0]};
   wire [REG_W-1:0] od_high = {od[G3], od[G2]};
   wire [REG_W-1:0] od_low = {od[G1], od[G0]};
   wire [REG_W-1:0] tm_high = enable_high_ff
      & {{NIB_W{trig[G3]}}, {NIB_W{trig[G2]}}};
   wire [REG_W-1:0] tm_low = enable_low_ff
      & {{NIB_W{trig[G1]}}, {NIB_W{trig[G0]}}};

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   reset_zero_a:
      assert property ($rose(resetn_in) |-> nd_high == 8'h00
         && nd_low == 8'h00)
      else $error("next data not zero after reset");
   shared_write_a:
      assert property (wr_lane && w_nh |=> nd_high == $past(wr_cmd.data))
      else $error("shared high write not stored");
   shared_high_rd_a:
      assert property (rd_pulse && r_nh |=> rdata_out[7:0] == $past(nd_high))
      else $error("shared high read wrong");
   split_high_rd_a:
      assert property (rd_pulse && r_nhl
         |=> rdata_out[7:0] == {4'hF, $past(nd[G2])})
      else $error("split high lower read wrong");
   shared_low_rd_a:
      assert property (rd_pulse && r_nl |=> rdata_out[7:0] == $past(nd_low))
      else $error("shared low read wrong");
   split_low_rd_a:
      assert property (rd_pulse && r_nlu
         |=> rdata_out[7:0] == {$past(nd[G1]), 4'hF})
      else $error("split low upper read wrong");
   split_ignore_a:
      assert property (wr_lane && w_nhu && !trig[G2] |=> $stable(nd[G2]))
      else $error("split write reached other nibble");
   high_xfer_a:
      assert property (ce_in
         |=> ((od_high ^ $past(nd_high)) & $past(tm_high)) == 8'h00)
      else $error("high transfer missing");
   low_xfer_a:
      assert property (ce_in
         |=> ((od_low ^ $past(nd_low)) & $past(tm_low)) == 8'h00)
      else $error("low transfer missing");
   disabled_hold_a:
      assert property (ce_in && !ow[G1]
         |=> ((od_low ^ $past(od_low)) & ~$past(enable_low_ff)) == 8'h00)
      else $error("disabled bit changed");
   enabled_block_a:
      assert property (ow[G3] && tm_high == 8'h00
         |=> ((od_high ^ $past(od_high)) & $past(enable_high_ff)) == 8'h00)
      else $error("cpu write reached enabled bit");
   trig_select_a:
      assert property (!compare_match_in[sel_ff[G3]] && !ow[G3]
         |=> $stable(od[G3]))
      else $error("wrong trigger channel");
   coincide_keep_a:
      assert property (nw[G3] && trig[G3] |=> nd[G3] == $past(wdat[G3]))
      else $error("coinciding write lost");
   ce_freeze_a:
      assert property (!ce_in |=> $stable(nd_high) && $stable(od_low))
      else $error("state moved while frozen");
endmodule

// *** tb/timer_match_model.sv ***
// timer compare-match source giving prompt or delayed pulses
`timescale 1ns/1ps
module timer_match_model
(
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [pulse_next_data_pkg::TIMER_CH-1:0] fire_in,
   input wire logic [3:0] wait_in,
   output logic [pulse_next_data_pkg::TIMER_CH-1:0] compare_match_out
);
   import pulse_next_data_pkg::*;
   logic [TIMER_CH-1:0] pend_ff;
   logic [3:0] cnt_ff;
   // each match is a single-cycle pulse unless fire_in is held high with wait_in zero
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pend_ff <= '0;
         cnt_ff <= 4'h0;
         compare_match_out <= '0;
      end
      else
      begin
         compare_match_out <= '0;
         if (|fire_in)
         begin
            pend_ff <= fire_in;
            cnt_ff <= wait_in;
            if (wait_in == 4'h0)
            begin
               compare_match_out <= fire_in;
               pend_ff <= '0;
            end
         end
         else if (|pend_ff)
         begin
            if (cnt_ff <= 4'h1)
            begin
               compare_match_out <= pend_ff;
               pend_ff <= '0;
            end
            else
               cnt_ff <= cnt_ff - 4'h1;
         end
      end
   end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the pulse next-data register bank
`timescale 1ns/1ps
module tb;
   import pulse_next_data_pkg::*;
   logic ref_clk, resetn, ce;
   logic [3:0] fire, wait_n, cm, wstrb;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [15:0] pulse, ph;
   logic [3:0] u, l;
   int bad_count, total_checks, k;

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   pulse_next_data_regs u_dut (.ref_clk_in(ref_clk), .resetn_in(resetn),
      .ce_in(ce), .compare_match_in(cm), .awaddr_in(awaddr),
      .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
      .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
      .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
      .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
      .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
      .rready_in(rready), .pulse_out(pulse));

   timer_match_model u_timer (.ref_clk_in(ref_clk), .resetn_in(resetn),
      .fire_in(fire), .wait_in(wait_n), .compare_match_out(cm));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // write one byte, release each channel when taken, wait for response
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      check("bvalid", bvalid, 1'b1);
      check("aw_w_taken", {awvalid, wvalid}, 2'b00);
      check("bresp", bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      check("rvalid", rvalid, 1'b1);
      check("ar_taken", arvalid, 1'b0);
      check("rdata", rdata, {24'h000000, ed});
      check("rresp", rresp, er);
   endtask

   // one match on channel ch after w extra cycles, then let it land
   task automatic trig(input int ch, input logic [3:0] w);
      @(posedge ref_clk);
      fire <= 4'(1 << ch);
      wait_n <= w;
      @(posedge ref_clk);
      fire <= 4'h0;
      repeat (w + 3) @(posedge ref_clk);
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end

   initial
   begin
      resetn = 1'b0;
      ce = 1'b1;
      fire = 4'h0;
      wait_n = 4'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      check("pulse", pulse, 16'h0000);
      rd(NEXT_HIGH_OFS, 8'h00, RESP_OKAY);
      rd(NEXT_LOW_OFS, 8'h00, RESP_OKAY);
      rd(TRIG_SEL_HIGH_OFS, 8'hFF, RESP_OKAY);
      rd(TRIG_SEL_LOW_OFS, 8'h0F, RESP_OKAY);
      rd(NEXT_HIGH_UPPER_OFS, 8'h00, RESP_SLVERR);
      rd(NEXT_LOW_LOWER_OFS, 8'h00, RESP_SLVERR);
      wr(8'h30, 8'h55, RESP_SLVERR);
      rd(8'h30, 8'h00, RESP_SLVERR);
      wr(NEXT_HIGH_OFS, 8'hA5, RESP_OKAY);
      rd(NEXT_HIGH_OFS, 8'hA5, RESP_OKAY);
      wr(NEXT_LOW_OFS, 8'h3C, RESP_OKAY);
      rd(NEXT_LOW_OFS, 8'h3C, RESP_OKAY);
      wr(OUTPUT_HIGH_OFS, 8'h0F, RESP_OKAY);
      check("pulse", pulse, 16'h0F00);
      wr(ENABLE_HIGH_OFS, 8'hFF, RESP_OKAY);
      wr(OUTPUT_HIGH_OFS, 8'h00, RESP_OKAY);
      rd(OUTPUT_HIGH_OFS, 8'h0F, RESP_OKAY);
      wr(OUTPUT_LOW_OFS, 8'h0A, RESP_OKAY);
      wr(ENABLE_LOW_OFS, 8'hF0, RESP_OKAY);
      // a match while the clock enable is low is lost
      @(posedge ref_clk);
      ce <= 1'b0;
      trig(3, 4'h0);
      ce <= 1'b1;
      check("pulse", pulse, 16'h0F0A);
      trig(3, 4'h3);
      ph = 16'hA53A;
      check("pulse", pulse, ph);
      for (k = 0; k < 4; k++)
      begin
         u = 4'(k + 5);
         l = 4'(k + 9);
         wr(TRIG_SEL_HIGH_OFS, {2'(k), 2'(k + 1), 4'h0}, RESP_OKAY);
         rd(TRIG_SEL_HIGH_OFS, {2'(k), 2'(k + 1), 4'hF},
            RESP_OKAY);
         wr(NEXT_HIGH_UPPER_OFS, {u, 4'h0}, RESP_OKAY);
         rd(NEXT_HIGH_UPPER_OFS, {u, 4'hF}, RESP_OKAY);
         wr(NEXT_HIGH_LOWER_OFS, {4'h0, l}, RESP_OKAY);
         rd(NEXT_HIGH_LOWER_OFS, {4'hF, l}, RESP_OKAY);
         rd(NEXT_HIGH_OFS, 8'h00, RESP_SLVERR);
         trig((k + 2) % 4, 4'h0);
         check("pulse", pulse, ph);
         trig(k, 4'h0);
         ph[15:12] = u;
         check("pulse", pulse, ph);
         trig((k + 1) % 4, 4'h0);
         ph[11:8] = l;
         check("pulse", pulse, ph);
      end
      wr(ENABLE_LOW_OFS, 8'hFF, RESP_OKAY);
      wr(TRIG_SEL_LOW_OFS, 8'h06, RESP_OKAY);
      rd(TRIG_SEL_LOW_OFS, 8'h06, RESP_OKAY);
      wr(NEXT_LOW_UPPER_OFS, 8'h95, RESP_OKAY);
      rd(NEXT_LOW_UPPER_OFS, 8'h9F, RESP_OKAY);
      wr(NEXT_LOW_LOWER_OFS, 8'h36, RESP_OKAY);
      rd(NEXT_LOW_LOWER_OFS, 8'hF6, RESP_OKAY);
      rd(NEXT_LOW_OFS, 8'h00, RESP_SLVERR);
      trig(1, 4'h0);
      ph[7:4] = 4'h9;
      check("pulse", pulse, ph);
      trig(2, 4'h0);
      ph[3:0] = 4'h6;
      check("pulse", pulse, ph);
      // store edge of the write meets the match edge
      wr(TRIG_SEL_HIGH_OFS, 8'hF0, RESP_OKAY);
      // stored value differs from the output so the transfer shows
      wr(NEXT_HIGH_OFS, 8'h5A, RESP_OKAY);
      fork
         wr(NEXT_HIGH_OFS, 8'h3C, RESP_OKAY);
         begin
            @(posedge ref_clk);
            fire <= 4'h8;
            wait_n <= 4'h0;
            @(posedge ref_clk);
            fire <= 4'h0;
         end
      join
      ph[15:8] = 8'h5A;
      repeat (2) @(posedge ref_clk);
      check("pulse", pulse, ph);
      rd(NEXT_HIGH_OFS, 8'h3C, RESP_OKAY);
      trig(3, 4'h0);
      ph[15:8] = 8'h3C;
      check("pulse", pulse, ph);
      give_verdict();
   end
endmodule
